// ===== rtl/ach_pkg.sv
// package: constants for the conversion handshake block
package ach_pkg;
    // ------------------------------------------------------------
    // data widths
    // ------------------------------------------------------------
    localparam int CODE_W = 8;
    localparam int ANALOG_W = 12;
    localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
    // scale factor applied before division by the span
    localparam int SCALE_SHIFT = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 40;
    localparam int CONV_TIME_US = 1;
    // least time: whole clock cycles, never below one cycle
    localparam int CONV_CYCLES_RAW = CONV_TIME_US * CLK_FREQ_MHZ;
    localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // state encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACH_IDLE,
        ACH_CONVERT,
        ACH_DONE
    } ach_state_t;
endpackage

// ===== rtl/ach_quantizer.sv
// quantizer: maps an input sample against the reference span to a code
module ach_quantizer
    import ach_pkg::*;
#(
    parameter int AW = ANALOG_W,
    parameter int CW = CODE_W
) (
    input wire logic [AW-1:0] analog_in_i,
    input wire logic [AW-1:0] ref_hi_i,
    input wire logic [AW-1:0] ref_lo_i,
    output logic [CW-1:0] code_o
);
    // ------------------------------------------------------------
    // span and scaled quotient
    // ------------------------------------------------------------
    logic [AW-1:0] full_scale_span;
    logic [AW+SCALE_SHIFT-1:0] scaled;
    logic [AW+SCALE_SHIFT-1:0] quotient;

    // span taken as upper minus lower reference
    always_comb begin
        if (ref_hi_i > ref_lo_i) begin
            full_scale_span = ref_hi_i - ref_lo_i;
        end else begin
            full_scale_span = '0;
        end
    end

    // integer quotient of input times 256 over span, then clamp
    always_comb begin
        scaled = {analog_in_i, {SCALE_SHIFT{1'b0}}};
        if (full_scale_span == '0) begin
            quotient = '0;
        end else begin
            quotient = scaled / {{SCALE_SHIFT{1'b0}}, full_scale_span};
        end
        // zero input gives zero; unsigned input cannot go below it
        if (analog_in_i == '0) begin
            code_o = '0;
        end else if (full_scale_span == '0 || analog_in_i >= full_scale_span) begin
            code_o = CODE_MAX;
        end else if (quotient > {{(AW+SCALE_SHIFT-CW){1'b0}}, CODE_MAX}) begin
            code_o = CODE_MAX;
        end else begin
            code_o = quotient[CW-1:0];
        end
    end
endmodule

// ===== rtl/ach_converter.sv
// converter control: start handshake, fixed conversion time, tri-state result
// Functional notes
// - done flag goes low on start and stays low while converting
// - conversion lasts one microsecond, then done flag returns high
// - after done returns high the finished code is presented on data outputs
// - data outputs driven while output_drive_enable, delayed three clocks, is high
// - span equals upper reference minus lower reference
// - code is integer of input times 256 over span, unsigned binary
module ach_converter
    import ach_pkg::*;
#(
    parameter int AW = ANALOG_W,
    parameter int CONV_CYC = CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic start_convert_i,
    input wire logic output_drive_enable_i,
    input wire logic [AW-1:0] analog_in_i,
    input wire logic [AW-1:0] ref_hi_i,
    input wire logic [AW-1:0] ref_lo_i,
    output logic conversion_done_o,
    output logic [CODE_W-1:0] code_out_o,
    output logic [CODE_W-1:0] code_out_oe_n_o
);
    // ------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------
    ach_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic done_q;
    logic [CODE_W-1:0] result_q;
    logic [CODE_W-1:0] oe_n_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // every pin but clk_i, reset_n_i and clk_en_i passes two flops before logic reads it; the first
    // stage may go metastable, so only the second stage reads it
    logic start_meta_q;
    logic start_sync_q;
    logic start_prev_q;
    logic oe_meta_q;
    logic oe_sync_q;
    logic [AW-1:0] ain_meta_q;
    logic [AW-1:0] ain_sync_q;
    logic [AW-1:0] hi_meta_q;
    logic [AW-1:0] hi_sync_q;
    logic [AW-1:0] lo_meta_q;
    logic [AW-1:0] lo_sync_q;

    // start request pin
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_meta_q <= 1'b0;
            start_sync_q <= 1'b0;
        end else if (clk_en_i) begin
            start_meta_q <= start_convert_i;
            start_sync_q <= start_meta_q;
        end
    end

    // edge history; resets low like the idle pin, so reset makes no false edge
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_prev_q <= 1'b0;
        end else if (clk_en_i) begin
            start_prev_q <= start_sync_q;
        end
    end

    // output enable pin
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oe_meta_q <= 1'b0;
            oe_sync_q <= 1'b0;
        end else if (clk_en_i) begin
            oe_meta_q <= output_drive_enable_i;
            oe_sync_q <= oe_meta_q;
        end
    end

    // sample and references: a word is only safe because the start edge, delayed
    // by the same two stages, qualifies it; the host holds them steady around start
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ain_meta_q <= '0;
            ain_sync_q <= '0;
            hi_meta_q <= '0;
            hi_sync_q <= '0;
            lo_meta_q <= '0;
            lo_sync_q <= '0;
        end else if (clk_en_i) begin
            ain_meta_q <= analog_in_i;
            ain_sync_q <= ain_meta_q;
            hi_meta_q <= ref_hi_i;
            hi_sync_q <= hi_meta_q;
            lo_meta_q <= ref_lo_i;
            lo_sync_q <= lo_meta_q;
        end
    end

    // ------------------------------------------------------------
    // start edge
    // ------------------------------------------------------------
    logic start_rise;
    logic busy;
    logic start_take;
    logic last_tick;

    // only the rising edge counts, so a held start makes one conversion
    assign start_rise = start_sync_q & ~start_prev_q;
    // a start edge during a conversion is dropped; the running one completes
    assign busy = (state_q == ACH_CONVERT);
    assign start_take = start_rise & ~busy;
    // final count of the conversion timer
    assign last_tick = busy & (cnt_q == '0);

    // ------------------------------------------------------------
    // sample capture and quantizer
    // ------------------------------------------------------------
    // sample is frozen at an accepted start so the result matches that instant
    logic [AW-1:0] sample_q;
    logic [AW-1:0] hi_q;
    logic [AW-1:0] lo_q;
    logic [CODE_W-1:0] quant_code;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sample_q <= '0;
            hi_q <= '0;
            lo_q <= '0;
        end else if (clk_en_i && start_take) begin
            sample_q <= ain_sync_q;
            hi_q <= hi_sync_q;
            lo_q <= lo_sync_q;
        end
    end

    ach_quantizer #(
        .AW(AW),
        .CW(CODE_W)
    ) u_quant (
        .analog_in_i(sample_q),
        .ref_hi_i(hi_q),
        .ref_lo_i(lo_q),
        .code_o(quant_code)
    );

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    // state: idle until the first start, done between conversions
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ACH_IDLE;
        end else if (clk_en_i) begin
            case (state_q)
                ACH_IDLE: begin
                    if (start_take) begin
                        state_q <= ACH_CONVERT;
                    end
                end
                ACH_CONVERT: begin
                    if (last_tick) begin
                        state_q <= ACH_DONE;
                    end
                end
                ACH_DONE: begin
                    if (start_take) begin
                        state_q <= ACH_CONVERT;
                    end
                end
                default: begin
                    state_q <= ACH_IDLE;
                end
            endcase
        end
    end

    // conversion timer: loaded at start, counts down to zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
        end else if (clk_en_i) begin
            if (start_take) begin
                cnt_q <= CNT_W'(CONV_CYC - 1);
            end else if (busy && cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // done flag: low for exactly the conversion time; start and the final
    // tick never fall in one cycle because a start is refused while busy
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_q <= 1'b1;
        end else if (clk_en_i) begin
            if (start_take) begin
                done_q <= 1'b0;
            end else if (last_tick) begin
                done_q <= 1'b1;
            end
        end
    end

    // result register: loaded at the edge that raises done, so the host
    // never sees done high with a stale code
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_q <= CODE_RESET;
        end else if (clk_en_i && last_tick) begin
            result_q <= quant_code;
        end
    end

    // ------------------------------------------------------------
    // tri-state data outputs
    // ------------------------------------------------------------
    // enable is active low per bit; reset releases the wire
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            oe_n_q <= '1;
        end else if (clk_en_i) begin
            oe_n_q <= {CODE_W{~oe_sync_q}};
        end
    end

    // every output comes straight from a flop
    assign conversion_done_o = done_q;
    assign code_out_o = result_q;
    assign code_out_oe_n_o = oe_n_q;
endmodule

// ===== test/ach_host_model.sv
// host model: drives start and read enable, resolves the shared data wire
module ach_host_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic rd_i,
    input wire logic [7:0] code_i,
    input wire logic [7:0] oe_n_i,
    output logic start_o,
    output logic oe_o,
    output logic [7:0] bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00;
    // host raises start to begin and holds it until the conversion is seen
    assign start_o = go_i;
    assign oe_o = rd_i;
    // released bits flip every cycle so a stale code never passes
    always_ff @(posedge clk_i) last_q <= bus_o;
    assign bus_o = (code_i & ~oe_n_i) | (~last_q & oe_n_i);
endmodule

// ===== test/ach_converter_properties.sv
// checker: port assertions for the converter control block
module ach_converter_properties
    import ach_pkg::*;
#(
    parameter int AW = ANALOG_W,
    parameter int CONV_CYC = CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic start_convert_i,
    input wire logic output_drive_enable_i,
    input wire logic [AW-1:0] analog_in_i,
    input wire logic [AW-1:0] ref_hi_i,
    input wire logic [AW-1:0] ref_lo_i,
    input wire logic conversion_done_o,
    input wire logic [CODE_W-1:0] code_out_o,
    input wire logic [CODE_W-1:0] code_out_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int a_q, s_q, low_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || !clk_en_i);
    // sample and span track the inputs until the done flag drops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            a_q <= 0;
            s_q <= 0;
        end else if (conversion_done_o) begin
            a_q <= int'(analog_in_i);
            s_q <= (ref_hi_i > ref_lo_i) ? int'(ref_hi_i) - int'(ref_lo_i) : 0;
        end
    end
    // counts low cycles of the done flag, too long for a repetition
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) low_q <= 0;
        else low_q <= conversion_done_o ? 0 : low_q + 1;
    end
    chk_done_falls: assert property ($rose(start_convert_i) && conversion_done_o
        |-> conversion_done_o[*3] ##1 !conversion_done_o) else $error("done did not fall");
    chk_conv_time: assert property ($rose(conversion_done_o) |-> low_q == CONV_CYC)
        else $error("conversion time wrong");
    chk_code_held: assert property (!$rose(conversion_done_o) |-> $stable(code_out_o))
        else $error("code changed outside completion");
    chk_code_value: assert property ($rose(conversion_done_o) && a_q < s_q
        |-> code_out_o == 8'(a_q * 256 / s_q)) else $error("code value wrong");
    chk_code_sat: assert property ($rose(conversion_done_o) && a_q != 0 && a_q >= s_q
        |-> code_out_o == CODE_MAX) else $error("code not saturated");
    chk_drive_on: assert property ($rose(output_drive_enable_i) ##1 output_drive_enable_i[*2]
        |=> code_out_oe_n_o == 8'h00) else $error("outputs not driven");
    chk_drive_off: assert property ($fell(output_drive_enable_i) ##1 !output_drive_enable_i[*2]
        |=> code_out_oe_n_o == 8'hFF) else $error("outputs not released");
endmodule
bind ach_converter ach_converter_properties #(.AW(AW), .CONV_CYC(CONV_CYC)) chk_u (.*);

// ===== test/tb_adc_conversion_handshake.sv
// testbench: converter control block against a queue model
module tb_adc_conversion_handshake;
    import ach_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CC = 8;
    logic clk_i = 0, reset_n_i = 0, go = 0, rd = 0, start, oe, done;
    logic [11:0] ain = 0, hi = 0, lo = 0;
    logic [7:0] code, oe_n, bus;
    int fails = 0, comparisons = 0;
    int q[$];
    ach_converter #(.CONV_CYC(CC)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .start_convert_i(start), .output_drive_enable_i(oe), .analog_in_i(ain), .ref_hi_i(hi),
        .ref_lo_i(lo), .conversion_done_o(done), .code_out_o(code), .code_out_oe_n_o(oe_n));
    ach_host_model host_u (.clk_i(clk_i), .go_i(go), .rd_i(rd), .code_i(code), .oe_n_i(oe_n),
        .start_o(start), .oe_o(oe), .bus_o(bus));
    always #12.5 clk_i = ~clk_i;
    task automatic step();
        @(posedge clk_i);
        #2;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // reference: zero stays zero, at or past the span saturates
    function automatic int model(input int a, input int h, input int l);
        int s;
        s = (h > l) ? h - l : 0;
        if (a == 0) return 0;
        if (a >= s) return 255;
        return a * 256 / s;
    endfunction
    // one full conversion, then a read through the shared wire
    task automatic convert(input int a, input int h, input int l, input bit poke = 1'b0);
        int n;
        logic [7:0] e;
        ain = 12'(a);
        hi = 12'(h);
        lo = 12'(l);
        q.push_back(model(a, h, l));
        go = 1;
        for (n = 0; n < 9 && done === 1'b1; n++) step();
        cmp({7'h00, done}, 8'h00);
        // a poke raises start again mid-conversion with a new sample: both ignored
        for (n = 0; n < 99 && done === 1'b0; n++) begin
            go = poke && n >= 2 && n < 5;
            if (poke && n == 2) ain = ~ain;
            step();
        end
        go = 0;
        cmp(8'(n), 8'(CC));
        e = 8'(q.pop_front());
        cmp(code, e);
        rd = 1;
        repeat (4) step();
        cmp(bus, e);
        rd = 0;
        repeat (4) step();
        cmp(oe_n, 8'hFF);
        repeat (2) step();
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (2000) @(posedge clk_i);
        fails++;
        results();
    end
    initial begin
        void'($urandom(32'h7DFCD635));
        repeat (10) @(posedge clk_i);
        #2;
        reset_n_i = 1;
        cmp({7'h00, done}, 8'h01);
        cmp(oe_n, 8'hFF);
        convert(0, 4095, 0);
        convert(4095, 4095, 0);
        convert(100, 50, 200);
        convert(4093, 4095, 1);
        convert(1, 4095, 0);
        convert(2000, 4000, 0, 1'b1);
        repeat (8) convert($urandom % 4096, $urandom % 4096, $urandom % 1024);
        results();
    end
endmodule
